// ===== rtl/drag_defines.vh
// constants for the display memory address generator
`ifndef DRAG_DEFINES_VH
`define DRAG_DEFINES_VH
`define DRAG_COLS 132
`define DRAG_LAST_COL 8'h83
`define DRAG_ROWS 65
`define DRAG_PAGES 8
`define DRAG_LAST_PAGE 4'h7
`define DRAG_EXTRA_PAGE 4'h8
`define DRAG_LINE_MOD 64
`define DRAG_AC_WRAP 0
`define DRAG_AC_DIR 2
`define DRAG_LC_MIRROR 3
`define DRAG_MUX_RESET 7'h41
`endif

// ===== rtl/drag_memory.v
// dual-port display memory, one byte column host port for writes and reads, one bit-slice scan read port
`timescale 1ns/1ps
`include "drag_defines.vh"
module drag_memory #(
  parameter COLS = `DRAG_COLS,
  parameter ROWS = `DRAG_ROWS
) (
  // clock
  input wire clk,
  // host port
  input wire wr_en,
  input wire [7:0] wr_col,
  input wire [3:0] wr_page,
  input wire [7:0] wr_data,
  input wire [7:0] rd_col,
  output reg [7:0] rd_data,
  // scan port
  input wire [6:0] scan_line,
  output reg [COLS-1:0] scan_slice
);
  reg [ROWS-1:0] mem [0:COLS-1];
  wire [COLS-1:0] slice_bits;
  genvar g;
  // ----------------------------------------
  // host write, no pipeline
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (wr_en && wr_col < COLS && wr_page < `DRAG_EXTRA_PAGE)
      mem[wr_col][{wr_page[2:0], 3'b000} +: 8] <= wr_data;
    else if (wr_en && wr_col < COLS && wr_page == `DRAG_EXTRA_PAGE)
      mem[wr_col][ROWS-1] <= wr_data[0];
  end
  // ----------------------------------------
  // per-column scan bits
  // ----------------------------------------
  generate
    for (g = 0; g < COLS; g = g + 1)
    begin : col
      assign slice_bits[g] = mem[g][scan_line];
    end
  endgenerate
  always @(posedge clk)
  begin
    scan_slice <= slice_bits;
  end
  // ----------------------------------------
  // host read, first pipeline stage
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (rd_col >= COLS || wr_page > `DRAG_EXTRA_PAGE)
      rd_data <= 8'h00;
    else if (wr_page == `DRAG_EXTRA_PAGE)
      rd_data <= {7'h00, mem[rd_col][ROWS-1]};
    else
      rd_data <= mem[rd_col][{wr_page[2:0], 3'b000} +: 8];
  end
endmodule

// ===== rtl/drag_addr_gen.v
// display memory address generator: host pointers and scan line sequence
`timescale 1ns/1ps
`include "drag_defines.vh"
module drag_addr_gen #(
  parameter COLS = `DRAG_COLS,
  parameter ROWS = `DRAG_ROWS
) (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // host pointer commands
  input wire set_column,
  input wire [7:0] column_value,
  input wire set_page,
  input wire [3:0] page_value,
  // host data access
  input wire data_write,
  input wire [7:0] write_data,
  input wire data_read,
  output reg [7:0] read_data,
  // configuration
  input wire wrap_enable,
  input wire page_step_direction,
  input wire column_mirror,
  input wire row_mirror,
  input wire [5:0] scroll_start_line,
  input wire [6:0] multiplex_ratio,
  // scan timing
  input wire field_start,
  input wire line_step,
  // status and scan output
  output reg [7:0] column_pointer,
  output reg [3:0] page_pointer,
  output reg [5:0] scan_line,
  output reg [COLS-1:0] column_electrode
);
  // ----------------------------------------
  // local constants
  // ----------------------------------------
  localparam [7:0] LAST_COL = `DRAG_LAST_COL;
  localparam [3:0] LAST_PAGE = `DRAG_LAST_PAGE;
  localparam [7:0] COL_STEP = 8'h01;
  localparam [3:0] PAGE_STEP = 4'h1;
  localparam [5:0] LINE_INC = 6'h01;
  // ----------------------------------------
  // internal signals
  // ----------------------------------------
  reg [7:0] next_column;
  reg [3:0] next_page;
  reg [5:0] next_line;
  reg [7:0] next_read;
  wire host_access;
  wire column_at_end;
  wire page_wraps;
  wire [3:0] page_up;
  wire [3:0] page_down;
  wire [7:0] phys_col;
  wire [7:0] mem_rd;
  wire [COLS-1:0] slice;
  wire [5:0] mux_rows;
  wire [5:0] first_line_plain;
  wire [5:0] first_line_mirror;
  wire [5:0] line_up;
  wire [5:0] line_down;
  // ----------------------------------------
  // host access decode
  // ----------------------------------------
  // pointer loads outrank data strobes
  assign host_access = (data_write || data_read) && !set_column && !set_page;
  assign column_at_end = (column_pointer >= LAST_COL);
  assign page_wraps = host_access && column_at_end && wrap_enable;
  // ----------------------------------------
  // page stepping with end-around
  // ----------------------------------------
  assign page_up = (page_pointer >= LAST_PAGE) ? 4'h0 : page_pointer + PAGE_STEP;
  assign page_down = (page_pointer == 4'h0) ? LAST_PAGE : page_pointer - PAGE_STEP;
  // ----------------------------------------
  // mirrored column selection
  // ----------------------------------------
  // mirror steers later accesses only
  assign phys_col = column_mirror ? (LAST_COL - column_pointer) : column_pointer;
  // ----------------------------------------
  // memory instance
  // ----------------------------------------
  // host and scan use separate ports
  drag_memory #(
    .COLS(COLS),
    .ROWS(ROWS)
  ) u_mem (
    .clk(clk),
    .wr_en(data_write),
    .wr_col(phys_col),
    .wr_page(page_pointer),
    .wr_data(write_data),
    .rd_col(phys_col),
    .rd_data(mem_rd),
    .scan_line({1'b0, scan_line}),
    .scan_slice(slice)
  );
  // ----------------------------------------
  // next column pointer
  // ----------------------------------------
  always @*
  begin
    next_column = column_pointer;
    if (set_column)
      next_column = column_value;
    else if (host_access && !column_at_end)
      next_column = column_pointer + COL_STEP;
    else if (page_wraps)
      next_column = 8'h00;
    else
      next_column = column_pointer;
  end
  // ----------------------------------------
  // next page pointer
  // ----------------------------------------
  always @*
  begin
    next_page = page_pointer;
    if (set_column)
      next_page = page_pointer;
    else if (set_page)
      next_page = page_value;
    else if (page_wraps && page_step_direction)
      next_page = page_down;
    else if (page_wraps)
      next_page = page_up;
    else
      next_page = page_pointer;
  end
  // ----------------------------------------
  // host read data hold
  // ----------------------------------------
  // second read stage, memory stage leads
  always @*
  begin
    next_read = read_data;
    if (data_read)
      next_read = mem_rd;
  end
  // ----------------------------------------
  // host pointer registers
  // ----------------------------------------
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      column_pointer <= 8'h00;
      page_pointer <= 4'h0;
    end
    else
    begin
      column_pointer <= next_column;
      page_pointer <= next_page;
    end
  end
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      read_data <= 8'h00;
    else
      read_data <= next_read;
  end
  // ----------------------------------------
  // scan line candidates
  // ----------------------------------------
  // six-bit sums wrap at 64
  assign mux_rows = multiplex_ratio[5:0];
  assign first_line_plain = scroll_start_line;
  assign first_line_mirror = scroll_start_line + mux_rows - LINE_INC;
  assign line_up = scan_line + LINE_INC;
  assign line_down = scan_line - LINE_INC;
  // ----------------------------------------
  // next scan line
  // ----------------------------------------
  // field start outranks line step
  always @*
  begin
    next_line = scan_line;
    if (field_start && row_mirror)
      next_line = first_line_mirror;
    else if (field_start)
      next_line = first_line_plain;
    else if (line_step && row_mirror)
      next_line = line_down;
    else if (line_step)
      next_line = line_up;
    else
      next_line = scan_line;
  end
  // ----------------------------------------
  // scan line register
  // ----------------------------------------
  // column electrode order never changes here
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      scan_line <= 6'h00;
    else
      scan_line <= next_line;
  end
  // ----------------------------------------
  // column driver slice
  // ----------------------------------------
  // line zero is bit 0 of each column
  always @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      column_electrode <= {COLS{1'b0}};
    else
      column_electrode <= slice;
  end
endmodule

// ===== verif/drag_addr_gen_monitor.sv
// assertion checker for the address generator
`timescale 1ns/1ps
module drag_check (
  // clock and reset
  input wire clk,
  input wire sys_rst,
  // host side
  input wire set_column,
  input wire [7:0] column_value,
  input wire set_page,
  input wire [3:0] page_value,
  input wire data_write,
  input wire data_read,
  // configuration and scan timing
  input wire wrap_enable,
  input wire page_step_direction,
  input wire row_mirror,
  input wire [5:0] scroll_start_line,
  input wire [6:0] multiplex_ratio,
  input wire field_start,
  input wire line_step,
  // watched outputs
  input wire [7:0] column_pointer,
  input wire [3:0] page_pointer,
  input wire [5:0] scan_line
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire acc = (data_write || data_read) && !set_column && !set_page;
  sequence s_end;
    acc && !set_page && column_pointer == 8'h83;
  endsequence
  ld_col_a: assert property (set_column |=> column_pointer == $past(column_value))
    else $error("col load");
  col_stop_a: assert property (!wrap_enable && acc && column_pointer == 8'h83 |=>
    column_pointer == 8'h83) else $error("col stop");
  col_inc_a: assert property (acc && column_pointer < 8'h83 |=>
    column_pointer == $past(column_pointer) + 8'h1) else $error("col inc");
  col_wrap_a: assert property (s_end ##0 wrap_enable |=> column_pointer == 8'h0)
    else $error("col wrap");
  pg_wrap_a: assert property (s_end ##0 wrap_enable && !page_step_direction &&
    page_pointer == 4'h7 |=> page_pointer == 4'h0) else $error("page wrap");
  pg_down_a: assert property (s_end ##0 wrap_enable && page_step_direction &&
    page_pointer == 4'h0 |=> page_pointer == 4'h7) else $error("page down wrap");
  pg_load_a: assert property (set_page && !set_column |=>
    page_pointer == $past(page_value)) else $error("page load");
  sl_first_a: assert property (field_start && !row_mirror |=>
    scan_line == $past(scroll_start_line)) else $error("line start");
  sl_step_a: assert property (line_step && !field_start && !row_mirror |=>
    scan_line == 6'($past(scan_line) + 6'h1)) else $error("line step");
  my_first_a: assert property (field_start && row_mirror |=> scan_line ==
    6'($past(scroll_start_line) + $past(multiplex_ratio) - 7'h1)) else $error("my start");
  my_step_a: assert property (line_step && !field_start && row_mirror |=>
    scan_line == 6'($past(scan_line) - 6'h1)) else $error("my step");
endmodule
bind drag_addr_gen drag_check u_chk (
  .clk(clk), .sys_rst(sys_rst), .set_column(set_column), .column_value(column_value),
  .set_page(set_page), .page_value(page_value), .data_write(data_write),
  .data_read(data_read), .wrap_enable(wrap_enable),
  .page_step_direction(page_step_direction), .row_mirror(row_mirror),
  .scroll_start_line(scroll_start_line), .multiplex_ratio(multiplex_ratio),
  .field_start(field_start), .line_step(line_step), .column_pointer(column_pointer),
  .page_pointer(page_pointer), .scan_line(scan_line)
);

// ===== verif/drag_host.sv
// host model issuing pointer commands and data accesses
`timescale 1ns/1ps
module drag_host (
  // clock
  input wire clk,
  // strobes and values
  output logic set_column,
  output logic set_page,
  output logic data_write,
  output logic data_read,
  output logic [7:0] column_value,
  output logic [7:0] write_data,
  output logic [3:0] page_value
);
  initial {set_column, set_page, data_write, data_read, column_value, write_data, page_value} = 0;
  // one pulse of kind k, released values turned over
  task automatic acc(input logic [3:0] k, input logic [7:0] v);
    @(posedge clk) #1;
    {set_column, set_page, data_write, data_read} = k;
    {column_value, write_data, page_value} = {v, v, v[3:0]};
    @(posedge clk) #1;
    {set_column, set_page, data_write, data_read} = 4'h0;
    {column_value, write_data, page_value} = ~{v, v, v[3:0]};
  endtask
endmodule

// ===== verif/drag_addr_gen_tb_top.sv
// testbench for the address generator
`timescale 1ns/1ps
module drag_addr_gen_tb_top;
  logic clk = 0, sys_rst = 1, wrap_enable = 0, page_step_direction = 0;
  logic column_mirror = 0, row_mirror = 0, field_start = 0, line_step = 0;
  logic [5:0] scroll_start_line = 6'h0;
  logic [6:0] multiplex_ratio = 7'h41;
  wire set_column, set_page, data_write, data_read;
  wire [7:0] column_value, write_data, read_data, column_pointer;
  wire [3:0] page_value, page_pointer;
  wire [5:0] scan_line;
  wire [131:0] column_electrode;
  int err_count = 0, checked = 0, cyc = 0;
  always #20 clk = ~clk;
  drag_host u_host (
    .clk(clk), .set_column(set_column), .set_page(set_page), .data_write(data_write),
    .data_read(data_read), .column_value(column_value), .write_data(write_data),
    .page_value(page_value)
  );
  drag_addr_gen u_dut (
    .clk(clk), .sys_rst(sys_rst), .set_column(set_column), .column_value(column_value),
    .set_page(set_page), .page_value(page_value), .data_write(data_write),
    .write_data(write_data), .data_read(data_read), .read_data(read_data),
    .wrap_enable(wrap_enable), .page_step_direction(page_step_direction),
    .column_mirror(column_mirror), .row_mirror(row_mirror),
    .scroll_start_line(scroll_start_line), .multiplex_ratio(multiplex_ratio),
    .field_start(field_start), .line_step(line_step), .column_pointer(column_pointer),
    .page_pointer(page_pointer), .scan_line(scan_line), .column_electrode(column_electrode)
  );
  task automatic chk(input string n, input logic [11:0] s, e);
    checked++;
    if (s !== e)
    begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  // one line period, then look at the slice two edges on
  task automatic scan(input logic f, input logic [5:0] l, input logic [1:0] e);
    @(posedge clk) #1;
    {field_start, line_step} = {f, !f};
    @(posedge clk) #1;
    {field_start, line_step} = 2'h0;
    chk("line", {6'h0, scan_line}, {6'h0, l});
    repeat (2) @(posedge clk);
    #1 chk("slice", {10'h0, column_electrode[126], column_electrode[5]}, {10'h0, e});
  endtask
  task automatic t_mem;
    u_host.acc(4'h8, 8'h05);
    u_host.acc(4'h4, 8'h00);
    u_host.acc(4'h2, 8'haa);
    chk("col", {4'h0, column_pointer}, 12'h006);
    column_mirror = 1;
    u_host.acc(4'h8, 8'h05);
    u_host.acc(4'h2, 8'h0f);
    scan(1, 6'h0, 2'h2);
    scan(0, 6'h1, 2'h3);
    row_mirror = 1;
    multiplex_ratio = 7'h3;
    scan(1, 6'h2, 2'h2);
    scan(0, 6'h1, 2'h3);
  endtask
  task automatic t_wrap;
    u_host.acc(4'h8, 8'h04);
    u_host.acc(4'h1, 8'h00);
    u_host.acc(4'h1, 8'h00);
    chk("mirror rd", {4'h0, read_data}, 12'h00f);
    column_mirror = 0;
    u_host.acc(4'h8, 8'h04);
    u_host.acc(4'h1, 8'h00);
    u_host.acc(4'h1, 8'h00);
    chk("rdata", {4'h0, read_data}, 12'h0aa);
    chk("read", {4'h0, column_pointer}, 12'h006);
    u_host.acc(4'h8, 8'h83);
    u_host.acc(4'h2, 8'h00);
    chk("stop", {4'h0, column_pointer}, 12'h083);
    wrap_enable = 1;
    u_host.acc(4'h4, 8'h07);
    u_host.acc(4'h8, 8'h83);
    u_host.acc(4'h1, 8'h00);
    chk("up", {page_pointer, column_pointer}, 12'h000);
    page_step_direction = 1;
    u_host.acc(4'h8, 8'h83);
    u_host.acc(4'h1, 8'h00);
    chk("down", {page_pointer, column_pointer}, 12'h700);
  endtask
  task final_report;
    if (err_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    #1 sys_rst = 0;
    t_mem;
    t_wrap;
    final_report;
  end
  always @(posedge clk)
    if (++cyc == 500)
    begin
      err_count++;
      final_report;
    end
endmodule
